//--- design/reset_source_sequencer.sv
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_map.svh"

// Overview of operation
// - internal reset clears registers, restarts at vector
// - ports forced to initial state without clock; brownout and watchdog resets force them only on a clock edge
// - stretch reset by fuse-selected delay after sources
// - exactly five reset causes recognised
// - power-on reset held while supply below threshold
// - supply falling below reasserts reset immediately
// - low reset pin asserts reset without clock
// - pin rising runs full start-up delay
// - watchdog reset only when enabled and expired
// - watchdog pulse one cycle, delay after it
// - brown-out asserts below level, delayed release
// - brown-out ignores dips shorter than 2 us
// - level fuse 111 disables, others select threshold
// - scan register one holds device in reset
// - cause flags set per source, power-on clears
// - power-on flag cleared only by software zero
module reset_source_sequencer
    import reset_seq_pkg::*;
#(
    parameter int unsigned STARTUP_UNIT_CYCLES = 16 // shortest start-up delay, doubled per fuse step
)
(
    input  wire logic        CLK_I,
    input  wire logic        RST_N_I,
    input  wire logic        POWER_GOOD_I,
    input  wire logic        RESET_PIN_N_I,
    input  wire logic        WDT_ENABLE_I,
    input  wire logic        WDT_TIMEOUT_I,
    input  wire logic [6:0]  BOD_BELOW_I,
    input  wire logic        SCAN_RESET_REG_I,
    input  wire logic [3:0]  AVS_ADDRESS_I,
    input  wire logic        AVS_READ_I,
    input  wire logic        AVS_WRITE_I,
    input  wire logic [31:0] AVS_WRITEDATA_I,
    input  wire logic [3:0]  AVS_BYTEENABLE_I,
    output logic [31:0]      AVS_READDATA_O,
    output logic             AVS_WAITREQUEST_O,
    output logic             SYS_RESET_N_O,
    output logic             IO_INIT_N_O
);

    localparam int unsigned BOD_MIN_CYC = `RS_BOD_MIN_CYC; // brownout_min_pulse in cycles

    ctrl_state_t          s_r;          // registered state
    ctrl_state_t          s_nxt;        // next state
    reset_seq_if          rs_bus ();    // link to the stretcher
    logic                 req;          // read or write pending
    logic                 accept;       // request completes this edge
    logic [2:0]           bod_level;    // brownout_level_fuse field
    logic                 bod_enable;   // brownout_detector switched on
    logic [7:0]           below_vec;    // comparator outputs, code 7 unused
    logic                 bod_below;    // supply below brownout_trigger_level
    logic [1:0]           sut_fuse;     // startup_time_fuse field
    logic [3:0]           cks_fuse;     // clock_select_fuse field
    logic [2:0]           delay_idx;    // combined fuse delay selector
    logic [`RS_FLG_W-1:0] flag_set;     // sources seen this cycle
    logic [`RS_FLG_W-1:0] flag_clr;     // software zero writes
    logic [31:0]          rd_mux;       // read data before registering
    logic [31:0]          status_word;  // live status

    // the three sources that act without a clock: power, pin and scan
    // register; glitches on these inputs reset the device, which is the
    // safe side for a reset controller
    assign rs_bus.arst_n = RST_N_I & POWER_GOOD_I & RESET_PIN_N_I & ~SCAN_RESET_REG_I;

    // brownout and the watchdog pulse are clocked sources held synchronously
    assign rs_bus.hold = s_r.bod_active | s_r.wdt_pulse;

    // fuse fields
    assign sut_fuse   = s_r.fuse[`RS_FUSE_SUT_LSB +: 2];
    assign cks_fuse   = s_r.fuse[`RS_FUSE_CKS_LSB +: 4];
    assign bod_level  = s_r.fuse[`RS_FUSE_BOD_LSB +: 3];
    assign bod_enable = (bod_level != `RS_BOD_OFF);
    assign below_vec  = {1'b0, BOD_BELOW_I};
    assign bod_below  = bod_enable & below_vec[bod_level];

    // start-up delay: unit doubled per step of the fuse selector
    assign delay_idx    = {cks_fuse[3], sut_fuse};
    assign rs_bus.delay = `RS_CNT_W'(STARTUP_UNIT_CYCLES << delay_idx);

    // bus handshake: answer one cycle after the request appears
    assign req    = AVS_READ_I | AVS_WRITE_I;
    assign accept = req & ~s_r.waitreq;

    // sources seen this cycle, one flag per cause other than power-on
    always_comb
    begin
        flag_set                    = '0;
        flag_set[`RS_FLG_PIN]       = ~RESET_PIN_N_I;
        flag_set[`RS_FLG_BROWNOUT]  = s_r.bod_active;
        flag_set[`RS_FLG_WATCHDOG]  = s_r.wdt_pulse;
        flag_set[`RS_FLG_SCAN]      = SCAN_RESET_REG_I;
        flag_clr = '0;
        if (accept && AVS_WRITE_I && AVS_ADDRESS_I == `RS_OFF_CAUSE && AVS_BYTEENABLE_I[0])
        begin
            // writing zero clears, writing one leaves the flag alone
            flag_clr = ~AVS_WRITEDATA_I[`RS_FLG_W-1:0];
        end
    end

    // status word shows the block's own state
    always_comb
    begin
        status_word                   = '0;
        status_word[`RS_STS_IN_RESET] = ~rs_bus.rst_n;
        status_word[`RS_STS_BROWNOUT] = s_r.bod_active;
        status_word[`RS_STS_COUNTING] = rs_bus.counting;
    end

    // read multiplexer; unmapped addresses read zero
    always_comb
    begin
        rd_mux = '0;
        unique case (AVS_ADDRESS_I)
            `RS_OFF_CAUSE:  rd_mux[`RS_FLG_W-1:0]  = s_r.flags;
            `RS_OFF_FUSE:   rd_mux[`RS_FUSE_W-1:0] = s_r.fuse;
            `RS_OFF_STATUS: rd_mux = status_word;
            default:        rd_mux = '0;
        endcase
    end

    // next-state logic for the bus, the flags and the source filters
    always_comb
    begin
        s_nxt = s_r;

        // avalon slave: waitrequest drops for the completing cycle only
        if (req && s_r.waitreq)
        begin
            s_nxt.waitreq = 1'b0;
            s_nxt.rdata   = rd_mux;
        end
        else
        begin
            s_nxt.waitreq = 1'b1;
        end

        // fuse image write, byte lanes honoured
        if (accept && AVS_WRITE_I && AVS_ADDRESS_I == `RS_OFF_FUSE)
        begin
            if (AVS_BYTEENABLE_I[0])
            begin
                s_nxt.fuse[7:0] = AVS_WRITEDATA_I[7:0];
            end
            if (AVS_BYTEENABLE_I[1])
            begin
                s_nxt.fuse[8] = AVS_WRITEDATA_I[8];
            end
        end

        // watchdog: one-cycle pulse on a time-out edge while enabled
        s_nxt.wdt_prev  = WDT_TIMEOUT_I;
        s_nxt.wdt_pulse = WDT_ENABLE_I & WDT_TIMEOUT_I & ~s_r.wdt_prev;

        // brownout filter: a dip must last the minimum pulse width
        if (bod_below)
        begin
            if (s_r.bod_cnt == `RS_BODCNT_W'(BOD_MIN_CYC - 1))
            begin
                s_nxt.bod_active = 1'b1;
            end
            else
            begin
                s_nxt.bod_cnt = s_r.bod_cnt + 1'b1;
            end
        end
        else
        begin
            // supply back above the level: the stretcher times the release
            s_nxt.bod_cnt    = '0;
            s_nxt.bod_active = 1'b0;
        end

        // cause flags: power-on clears the others and sets its own
        if (!POWER_GOOD_I)
        begin
            s_nxt.flags = `RS_CAUSE_RST;
        end
        else
        begin
            // set wins over a clear arriving in the same cycle
            s_nxt.flags = (s_r.flags & ~flag_clr) | flag_set;
        end
    end

    // single register for all control state; only the controller's own
    // supply reset clears it, so the flags survive the resets they record
    always_ff @(posedge CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            s_r.flags      <= `RS_CAUSE_RST;
            s_r.fuse       <= `RS_FUSE_RST;
            s_r.bod_cnt    <= '0;
            s_r.bod_active <= 1'b0;
            s_r.wdt_prev   <= 1'b0;
            s_r.wdt_pulse  <= 1'b0;
            s_r.waitreq    <= 1'b1;
            s_r.rdata      <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // release synchroniser and delay counter
    reset_stretcher u_stretch (
        .clk_i (CLK_I),
        .bus   (rs_bus.stretch)
    );

    // outputs straight from flops; SYS_RESET_N_O low restarts the core at the vector
    assign SYS_RESET_N_O     = rs_bus.rst_n;
    assign IO_INIT_N_O       = rs_bus.io_n;
    assign AVS_READDATA_O    = s_r.rdata;
    assign AVS_WAITREQUEST_O = s_r.waitreq;

    // a time-out edge with the watchdog enabled
    sequence s_wdt_fire;
        WDT_ENABLE_I && WDT_TIMEOUT_I && !s_r.wdt_prev;
    endsequence

    // the resulting pulse: high for one cycle, then low
    sequence s_one_cycle_pulse;
        s_r.wdt_pulse ##1 !s_r.wdt_pulse;
    endsequence

    a_wdt_pulse_once: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        s_wdt_fire |=> s_one_cycle_pulse)
        else $error("watchdog pulse not exactly one cycle");

    a_wdt_gated_enable: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !WDT_ENABLE_I |=> !s_r.wdt_pulse)
        else $error("watchdog reset while disabled");

    a_bod_min_width: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        $rose(s_r.bod_active) |-> ($past(s_r.bod_cnt) == `RS_BODCNT_W'(BOD_MIN_CYC - 1)))
        else $error("brownout fired before minimum pulse width");

    a_bod_fuse_off: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (bod_level == `RS_BOD_OFF) ##1 (bod_level == `RS_BOD_OFF) |-> !s_r.bod_active)
        else $error("brownout active while disabled by fuse");

    a_bod_holds_reset: assert property (@(posedge CLK_I) disable iff (!rs_bus.arst_n)
        s_r.bod_active |=> !SYS_RESET_N_O)
        else $error("brownout did not hold internal reset");

    a_por_flags_init: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        !POWER_GOOD_I |=> (s_r.flags == `RS_CAUSE_RST))
        else $error("power-on did not reset cause flags");

    a_por_flag_sticky: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (s_r.flags[`RS_FLG_POWER] && !flag_clr[`RS_FLG_POWER]) |=> s_r.flags[`RS_FLG_POWER])
        else $error("power-on flag lost without a software zero");

    a_pin_sets_flag: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!RESET_PIN_N_I && POWER_GOOD_I) |=> s_r.flags[`RS_FLG_PIN])
        else $error("pin reset not recorded");

endmodule

`default_nettype wire

//--- pkg/reset_seq_map.svh
`ifndef RESET_SEQ_MAP_SVH
`define RESET_SEQ_MAP_SVH

// register byte offsets on the avalon slave
`define RS_OFF_CAUSE      4'h0
`define RS_OFF_FUSE       4'h4
`define RS_OFF_STATUS     4'h8

// reset_cause_register bit positions
`define RS_FLG_POWER      0
`define RS_FLG_PIN        1
`define RS_FLG_BROWNOUT   2
`define RS_FLG_WATCHDOG   3
`define RS_FLG_SCAN       4
`define RS_FLG_W          5

// reset values: only the power-on flag is set after a cold start
`define RS_CAUSE_RST      5'h01

// fuse image layout and reset value
`define RS_FUSE_W         9
`define RS_FUSE_SUT_LSB   0
`define RS_FUSE_CKS_LSB   2
`define RS_FUSE_BOD_LSB   6
`define RS_FUSE_RST       9'h1c2
`define RS_BOD_OFF        3'h7

// status register bit positions
`define RS_STS_IN_RESET   0
`define RS_STS_BROWNOUT   1
`define RS_STS_COUNTING   2

// timing: brownout_min_pulse, clock period, derived cycle count (least time, round up)
`define RS_CLK_PERIOD_NS  40
`define RS_BOD_MIN_NS     2000
`define RS_BOD_MIN_CYC    ((`RS_BOD_MIN_NS + `RS_CLK_PERIOD_NS - 1) / `RS_CLK_PERIOD_NS)

// counter widths
`define RS_CNT_W          24
`define RS_BODCNT_W       8

`endif

//--- pkg/reset_seq_pkg.sv
`include "reset_seq_map.svh"

package reset_seq_pkg;

    // state of the bus, flag and source-filter side
    typedef struct packed {
        logic [`RS_FLG_W-1:0]    flags;      // reset_cause_register image
        logic [`RS_FUSE_W-1:0]   fuse;       // fuse image
        logic [`RS_BODCNT_W-1:0] bod_cnt;    // brownout dip length counter
        logic                    bod_active; // filtered brownout reset source
        logic                    wdt_prev;   // last watchdog time-out level
        logic                    wdt_pulse;  // one-cycle watchdog reset pulse
        logic                    waitreq;    // avalon waitrequest
        logic [31:0]             rdata;      // avalon read data
    } ctrl_state_t;

    // state of the release synchroniser and start-up delay counter
    typedef struct packed {
        logic                 sync1;    // first synchroniser stage
        logic                 sync2;    // second synchroniser stage
        logic [`RS_CNT_W-1:0] cnt;      // startup_delay_timeout counter
        logic                 rst_n;    // internal reset, active low
        logic                 io_n;     // i/o port initialisation, active low
        logic                 counting; // delay counter running
    } stretch_state_t;

endpackage

//--- pkg/reset_seq_if.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_map.svh"

// carries the combined sources to the stretcher and its result back
interface reset_seq_if;
    import reset_seq_pkg::*;
    logic                 arst_n;   // asynchronous sources combined, active low
    logic                 hold;     // clocked sources (brownout, watchdog pulse)
    logic [`RS_CNT_W-1:0] delay;    // start-up delay length in cycles
    logic                 rst_n;    // internal reset from the stretcher flop
    logic                 io_n;     // port initialisation from the stretcher flop
    logic                 counting; // delay counter busy

    modport ctrl    (output arst_n, output hold, output delay, input rst_n, input io_n, input counting);
    modport stretch (input arst_n, input hold, input delay, output rst_n, output io_n, output counting);
endinterface

`default_nettype wire

//--- design/reset_stretcher.sv
`timescale 1ns/1ps
`default_nettype none

module reset_stretcher
    import reset_seq_pkg::*;
(
    input  wire logic      clk_i,
    reset_seq_if.stretch   bus
);

    stretch_state_t s_r;   // registered state
    stretch_state_t s_nxt; // next state

    // next-state logic: release only after the synchroniser and the full delay
    always_comb
    begin
        s_nxt       = s_r;
        s_nxt.sync1 = 1'b1;
        s_nxt.sync2 = s_r.sync1;
        if (!s_r.sync2 || bus.hold)
        begin
            // any source active: clear the counter and hold reset
            s_nxt.cnt      = '0;
            s_nxt.rst_n    = 1'b0;
            s_nxt.io_n     = 1'b0;
            s_nxt.counting = 1'b0;
        end
        else if (s_r.rst_n)
        begin
            // running normally, nothing to do
            s_nxt.counting = 1'b0;
        end
        else if (s_r.cnt >= bus.delay)
        begin
            // full time-out elapsed: release both outputs together
            s_nxt.rst_n    = 1'b1;
            s_nxt.io_n     = 1'b1;
            s_nxt.counting = 1'b0;
        end
        else
        begin
            s_nxt.cnt      = s_r.cnt + 1'b1;
            s_nxt.counting = 1'b1;
        end
    end

    // assertion is asynchronous through arst_n, so no clock is needed to
    // force the ports; release always waits for two clean edges
    always_ff @(posedge clk_i or negedge bus.arst_n)
    begin
        if (!bus.arst_n)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign bus.rst_n    = s_r.rst_n;
    assign bus.io_n     = s_r.io_n;
    assign bus.counting = s_r.counting;

    // reset may only rise after exactly the programmed delay
    a_release_after_delay: assert property (@(posedge clk_i) disable iff (!bus.arst_n)
        $rose(s_r.rst_n) |-> ($past(s_r.cnt) == $past(bus.delay)))
        else $error("reset released before the delay expired");

    // a clocked source always restarts the count from zero
    a_source_restarts: assert property (@(posedge clk_i) disable iff (!bus.arst_n)
        bus.hold |=> (!s_r.rst_n && s_r.cnt == '0))
        else $error("delay counter not cleared by a reasserted source");

    // no release while the synchroniser is still filling
    a_sync_release: assert property (@(posedge clk_i) disable iff (!bus.arst_n)
        !s_r.sync2 |=> !s_r.rst_n ##1 !s_r.rst_n)
        else $error("reset released without synchronisation");

endmodule

`default_nettype wire

//--- testbench/source_model.sv
`timescale 1ns/1ps
`default_nettype none

// far side of the sequencer: supply comparators, reset pin and watchdog
module source_model (
    input  wire logic       clk_i,
    output logic            power_good_o,
    output logic            pin_n_o,
    output logic            wdt_en_o,
    output logic            wdt_to_o,
    output logic [6:0]      bod_below_o,
    output logic            scan_o
);
    // healthy supply, pin released, watchdog quiet at time zero
    initial
    begin
        power_good_o = 1'b1;
        pin_n_o      = 1'b1;
        wdt_en_o     = 1'b0;
        wdt_to_o     = 1'b0;
        bod_below_o  = 7'h00;
        scan_o       = 1'b0;
    end

    // level sources change just after a rising edge, all at once
    task automatic drive(input logic pg, input logic pin_n, input logic scan, input logic [6:0] brownout_detector);
        @(posedge clk_i);
        power_good_o <= pg;
        pin_n_o      <= pin_n;
        scan_o       <= scan;
        bod_below_o  <= brownout_detector;
    endtask

    // watchdog enable is a plain level
    task automatic enable_wdt(input logic en);
        @(posedge clk_i);
        wdt_en_o <= en;
    endtask

    // expiry is a rising level, held two cycles so it is never missed
    task automatic expire_wdt();
        @(posedge clk_i);
        wdt_to_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        wdt_to_o <= 1'b0;
    endtask
endmodule

`default_nettype wire

//--- testbench/reset_source_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "reset_seq_map.svh"

module reset_source_sequencer_bench;
    import reset_seq_pkg::*;
    localparam int unsigned UNIT = 4;  // short start-up unit keeps every stretch small
    localparam int unsigned D    = 16; // fuse sut=2, cks=0: UNIT << 2

    logic        clk = 1'b0;     // 25 MHz system clock
    logic        rst_n = 1'b0;   // controller reset
    logic        pg;             // supply good
    logic        pin_n;          // reset pin
    logic        wdt_en;         // watchdog enable
    logic        wdt_to;         // watchdog expiry
    logic [6:0]  brownout_detector;            // brownout comparators
    logic        scan;           // scan-port reset register
    logic [3:0]  addr = 4'h0;    // bus address
    logic        rd = 1'b0;      // bus read strobe
    logic        wr = 1'b0;      // bus write strobe
    logic [31:0] wdata = 32'h0;  // bus write data
    logic [31:0] rdata;          // bus read data
    logic        wreq;           // waitrequest
    logic        sys_n;          // internal reset
    logic        io_n;           // port initialisation
    int          err_total = 0;  // mismatches
    int          checks = 0;     // comparisons

    always #20 clk = ~clk;

    source_model u_src (.clk_i(clk), .power_good_o(pg), .pin_n_o(pin_n), .wdt_en_o(wdt_en),
                        .wdt_to_o(wdt_to), .bod_below_o(brownout_detector), .scan_o(scan));

    reset_source_sequencer #(.STARTUP_UNIT_CYCLES(UNIT)) u_dut (
        .CLK_I(clk), .RST_N_I(rst_n), .POWER_GOOD_I(pg), .RESET_PIN_N_I(pin_n),
        .WDT_ENABLE_I(wdt_en), .WDT_TIMEOUT_I(wdt_to), .BOD_BELOW_I(brownout_detector), .SCAN_RESET_REG_I(scan),
        .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata),
        .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wreq),
        .SYS_RESET_N_O(sys_n), .IO_INIT_N_O(io_n));

    // the single place where the run ends
    task automatic report_and_stop();
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one bus cycle: hold the request until waitrequest is sampled low
    task automatic bus(input logic wrt, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        rd    <= ~wrt;
        wr    <= wrt;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 20);
        q  = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (n >= 20)
        begin
            err_total++;
            report_and_stop();
        end
    endtask

    task automatic rreg(input logic [3:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp, what);
    endtask

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    // counts edges from the last source release to the rise of internal reset
    task automatic expect_release(input int unsigned d);
        int unsigned n;
        n = 0;
        while (sys_n !== 1'b1 && n < 400)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 400)
        begin
            err_total++;
            report_and_stop();
        end
        chk(32'(n >= d && n <= d + 5), 32'h1, "stretch length");
        chk({31'h0, io_n}, 32'h1, "port init follows");
    endtask

    // applies a reset source, checks it bites at once, releases it and times the stretch
    task automatic pulse(input logic pg_v, input logic pin_v, input logic scan_v, input int unsigned hold);
        u_src.drive(pg_v, pin_v, scan_v, 7'h00);
        #1;
        chk({30'h0, sys_n, io_n}, 32'h0, "reset without clock edge");
        repeat (hold) @(posedge clk);
        chk({31'h0, sys_n}, 32'h0, "reset held by source");
        u_src.drive(1'b1, 1'b1, 1'b0, 7'h00);
        expect_release(D);
    endtask

    task automatic t_defaults();
        rreg(`RS_OFF_CAUSE, 32'h01, "cause after reset");
        rreg(`RS_OFF_FUSE, 32'h1c2, "fuse after reset");
        wreg(4'hc, 32'hffff_ffff);
        rreg(4'hc, 32'h0, "unmapped read");
        rreg(`RS_OFF_CAUSE, 32'h01, "unmapped write ignored");
        wreg(`RS_OFF_CAUSE, 32'h0);
        rreg(`RS_OFF_CAUSE, 32'h0, "power flag cleared by zero");
    endtask

    task automatic t_pin_scan();
        pulse(1'b1, 1'b0, 1'b0, 3);
        rreg(`RS_OFF_CAUSE, 32'h02, "pin flag only");
        pulse(1'b1, 1'b1, 1'b1, 100);
        rreg(`RS_OFF_CAUSE, 32'h12, "scan flag added");
        wreg(`RS_OFF_CAUSE, 32'h0);
    endtask

    // a source returning mid-stretch restarts the whole count
    task automatic t_restart();
        u_src.drive(1'b1, 1'b0, 1'b0, 7'h00);
        u_src.drive(1'b1, 1'b1, 1'b0, 7'h00);
        repeat (10) @(posedge clk);
        chk({31'h0, sys_n}, 32'h0, "still stretching");
        rreg(`RS_OFF_STATUS, 32'h5, "status while stretching");
        pulse(1'b1, 1'b0, 1'b0, 1);
        wreg(`RS_OFF_CAUSE, 32'h0);
    endtask

    task automatic t_wdt();
        u_src.expire_wdt();
        repeat (5) @(posedge clk);
        chk({31'h0, sys_n}, 32'h1, "disabled watchdog ignored");
        rreg(`RS_OFF_CAUSE, 32'h0, "no watchdog flag");
        u_src.enable_wdt(1'b1);
        u_src.expire_wdt();
        #1;
        chk({31'h0, sys_n}, 32'h0, "watchdog reset");
        expect_release(D - 3);
        rreg(`RS_OFF_CAUSE, 32'h08, "watchdog flag");
        u_src.enable_wdt(1'b0);
        wreg(`RS_OFF_CAUSE, 32'h0);
    endtask

    // every enabled level code, a short dip, and the disabled code
    task automatic brownout_min_pulse();
        for (int k = 0; k < 7; k++)
        begin
            wreg(`RS_OFF_FUSE, 32'((k << 6) | 2));
            u_src.drive(1'b1, 1'b1, 1'b0, 7'(1 << k));
            repeat (60) @(posedge clk);
            chk({31'h0, sys_n}, 32'h0, "brownout reset");
            rreg(`RS_OFF_STATUS, 32'h3, "status in brownout");
            u_src.drive(1'b1, 1'b1, 1'b0, 7'h00);
            expect_release(D);
            rreg(`RS_OFF_CAUSE, 32'h04, "brownout flag");
            wreg(`RS_OFF_CAUSE, 32'h0);
        end
        u_src.drive(1'b1, 1'b1, 1'b0, 7'h40);
        repeat (30) @(posedge clk);
        u_src.drive(1'b1, 1'b1, 1'b0, 7'h00);
        repeat (5) @(posedge clk);
        chk({31'h0, sys_n}, 32'h1, "short dip ignored");
        wreg(`RS_OFF_FUSE, 32'h1c2);
        u_src.drive(1'b1, 1'b1, 1'b0, 7'h7f);
        repeat (70) @(posedge clk);
        chk({31'h0, sys_n}, 32'h1, "brownout disabled");
        u_src.drive(1'b1, 1'b1, 1'b0, 7'h00);
        rreg(`RS_OFF_CAUSE, 32'h0, "no flag when disabled");
    endtask

    // supply loss reasserts at once and leaves only the power flag
    task automatic t_power();
        pulse(1'b1, 1'b0, 1'b0, 2);
        pulse(1'b0, 1'b1, 1'b0, 4);
        rreg(`RS_OFF_CAUSE, 32'h01, "power clears other flags");
    endtask

    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        expect_release(D);
        t_defaults();
        t_pin_scan();
        t_restart();
        t_wdt();
        brownout_min_pulse();
        t_power();
        report_and_stop();
    end
endmodule

`default_nettype wire
